// ---- rtl/atg_pkg.sv ----
// constants, register map and types for the acquisition trigger and timing block
package atg_pkg;
  localparam int QDEPTH = 16;
  localparam int QAW = 4;
  localparam int SW = 16;
  localparam logic [4:0] QFULL = 5'h10;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_IN_CFG = 8'h04;
  localparam logic [7:0] A_IN_CNT = 8'h08;
  localparam logic [7:0] A_IN_TIM = 8'h0c;
  localparam logic [7:0] A_OUT_CFG = 8'h10;
  localparam logic [7:0] A_OUT_CNT = 8'h14;
  localparam logic [7:0] A_OUT_TIM = 8'h18;
  localparam logic [7:0] A_OUT_DATA = 8'h1c;
  localparam logic [7:0] A_ROUTE = 8'h20;
  localparam logic [7:0] A_STATUS = 8'h24;
  // command bits, write-one pulses
  localparam int C_IN_START = 0;
  localparam int C_IN_STOP = 1;
  localparam int C_IN_SWTRIG = 2;
  localparam int C_OUT_START = 3;
  localparam int C_OUT_STOP = 4;
  localparam int C_OUT_SWTRIG = 5;
  localparam int C_FLUSH = 6;
  // engine configuration fields
  localparam int F_USE_TRIG = 0;
  localparam int F_RETRIG = 1;
  localparam int F_CONT = 2;
  localparam int F_FALL = 3;
  localparam int F_SRC = 4;
  localparam int F_LINE = 8;
  localparam int IC_CONV_TB = 12;
  localparam int IC_NCONV = 16;
  localparam int OC_MODE = 12;
  localparam int T_DLY = 0;
  localparam int T_SDIV = 8;
  localparam int IT_CDIV = 16;
  localparam int RT_HOLD_EN = 0;
  localparam int RT_HOLD_LINE = 4;
  localparam int RT_HOLD_POL = 8;
  localparam int RT_IN_EN = 12;
  localparam int RT_IN_LINE = 16;
  localparam int RT_OUT_EN = 20;
  localparam int RT_OUT_LINE = 24;
  localparam int ST_IN_BUSY = 0;
  localparam int ST_OUT_BUSY = 1;
  localparam int ST_UNDER = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_LEVEL = 8;
  // reset values: input start delay 4 ticks, output start delay 2 ticks
  localparam logic [31:0] IN_CFG_RST = 32'h0001_0000;
  localparam logic [31:0] CNT_RST = 32'h0000_0001;
  localparam logic [31:0] IN_TIM_RST = 32'h0001_0104;
  localparam logic [31:0] OUT_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] OUT_TIM_RST = 32'h0000_0102;
  localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // trigger source codes
  localparam logic [1:0] ISRC_IO = 2'h0;
  localparam logic [1:0] ISRC_CNT = 2'h1;
  localparam logic [2:0] OSRC_SW = 3'h0;
  localparam logic [2:0] OSRC_IO = 3'h1;
  localparam logic [2:0] OSRC_IN = 3'h2;
  localparam logic [2:0] OSRC_CNT = 3'h3;
  localparam logic [2:0] OSRC_CHG = 3'h4;
  localparam logic [2:0] OSRC_DI = 3'h5;
  localparam logic [2:0] OSRC_DO = 3'h6;
  typedef enum logic [1:0] {E_IDLE, E_WAIT, E_DELAY, E_RUN} atg_eng_t;
  typedef enum logic [1:0] {OM_SW, OM_REPEAT_BUFFER, OM_LOCAL_QUEUE_REPLAY, OM_NOREGEN} atg_omode_t;
endpackage

// ---- rtl/atg_top.sv ----
// trigger and timing engine for acquisition and waveform generation
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - conversion timebase selectable, divided to conversion clock
// - conversion timebase never routed to terminals
// - one hold-done pulse per conversion start
// - hold-done pulse routable to any io line
// - hold-done polarity on the routed io line chosen by software
// - untriggered start by command; finite or continuous
// - retriggerable input gives full burst per trigger
// - input triggers ignored during burst
// - input trigger source and edge selectable
// - input start trigger drivable onto io line
// - software trigger starts pre-triggered input
// - software-timed output: one update per data write
// - output finite count or continuous until stop
// - repeat buffer replays, writes replace data
// - local queue replay refuses writes while running
// - non-repeating output flags underflow when empty
// - untriggered output starts by command
// - retriggerable output gives full burst per trigger
// - output triggers ignored during burst
// - output trigger source and edge selectable
// - output start trigger drivable onto io line
// - input start delay default four ticks
// - output start delay default two ticks
module atg_top import atg_pkg::*; (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // io terminals
  input wire logic [15:0] general_io_lines_in,
  output logic [15:0] general_io_lines_out,
  output logic [15:0] general_io_lines_oe,
  // internal trigger sources
  input wire logic counter_out,
  input wire logic change_detect,
  input wire logic digital_in_start_trigger,
  input wire logic digital_out_start_trigger,
  // timebase ticks, one-cycle pulses
  input wire logic sample_tb_tick,
  input wire logic hf_tb_tick,
  input wire logic out_tb_tick,
  // timing outputs
  output logic in_sample_clk,
  output logic conv_clk,
  output logic hold_done_pulse,
  output logic input_start_trigger,
  output logic output_start_trigger,
  output logic out_sample_clk,
  output logic dac_update,
  output logic [SW-1:0] dac_data
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] in_cfg;
    logic [31:0] in_cnt;
    logic [31:0] in_tim;
    logic [31:0] out_cfg;
    logic [31:0] out_cnt;
    logic [31:0] out_tim;
    logic [31:0] route;
    logic [15:0] io_q1;
    logic [15:0] io_q2;
    logic [15:0] io_q3;
    logic [15:0] io_st;
    logic [15:0] io_prev;
    logic [3:0] ext_prev;
    atg_eng_t in_st;
    logic [7:0] in_div;
    logic [15:0] in_done;
    logic in_last;
    logic [3:0] conv_left;
    logic [7:0] conv_div;
    atg_eng_t out_st;
    logic [7:0] out_div;
    logic [15:0] out_done;
    logic [QDEPTH-1:0][SW-1:0] mem;
    logic [QAW-1:0] wr_ptr;
    logic [QAW-1:0] rd_ptr;
    logic [4:0] level;
    logic underflow;
    logic refused;
    logic in_smp;
    logic conv;
    logic in_trig;
    logic out_trig;
    logic out_smp;
    logic dac_upd;
    logic [SW-1:0] dac_data;
    logic [15:0] io_out;
    logic [15:0] io_oe;
  } atg_state_t;

  atg_state_t s;
  atg_state_t n;
  atg_state_t rst_val;
  logic wr_do;
  logic wr_data;
  logic wr_stat;
  logic [7:0] cmd;
  logic [31:0] rd_val;
  logic rd_ok;
  logic in_now;
  logic in_was;
  logic in_trig_ev;
  logic in_accept;
  logic in_smp_go;
  logic conv_tick;
  logic out_now;
  logic out_was;
  logic out_trig_ev;
  logic out_accept;
  logic out_smp_go;
  logic out_end;
  logic o_push;
  logic o_pop;
  logic o_keep;
  atg_omode_t omode;
  logic [7:0] in_sdiv_m1;
  logic [7:0] out_sdiv_m1;
  logic [3:0] ext_now;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    rst_val = '0;
    rst_val.in_cfg = IN_CFG_RST;
    rst_val.in_cnt = CNT_RST;
    rst_val.in_tim = IN_TIM_RST;
    rst_val.out_cfg = OUT_CFG_RST;
    rst_val.out_cnt = CNT_RST;
    rst_val.out_tim = OUT_TIM_RST;
    rst_val.route = ROUTE_RST;
    rst_val.in_st = E_IDLE;
    rst_val.out_st = E_IDLE;
  end

  // readies gated by ce so a frozen block never completes a handshake
  assign s_axi_awready = ce & ~s.aw_got;
  assign s_axi_wready = ce & ~s.w_got;
  assign s_axi_bvalid = ce & s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = ce & ~s.rvalid;
  assign s_axi_rvalid = ce & s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign wr_do = s.aw_got & s.w_got & ~s.bvalid;
  assign wr_data = wr_do && (s.awaddr == A_OUT_DATA);
  assign wr_stat = wr_do && (s.awaddr == A_STATUS) && s.wstrb[0];
  assign cmd = (wr_do && (s.awaddr == A_CTRL) && s.wstrb[0]) ? s.wdata[7:0] : 8'h00;
  assign omode = atg_omode_t'(s.out_cfg[OC_MODE +: 2]);
  assign in_sdiv_m1 = (s.in_tim[T_SDIV +: 8] == 8'h00) ? 8'h00 : s.in_tim[T_SDIV +: 8] - 8'h01;
  assign out_sdiv_m1 = (s.out_tim[T_SDIV +: 8] == 8'h00) ? 8'h00 : s.out_tim[T_SDIV +: 8] - 8'h01;
  assign ext_now = {digital_out_start_trigger, digital_in_start_trigger, change_detect, counter_out};

  // trigger source selection; other input sources leave only the software pulse, other output sources the software pulse at OSRC_SW, the input trigger at OSRC_IN
  always_comb begin
    in_now = 1'b0;
    in_was = 1'b0;
    unique case (s.in_cfg[F_SRC +: 2])
      ISRC_IO: begin
        in_now = s.io_st[s.in_cfg[F_LINE +: 4]];
        in_was = s.io_prev[s.in_cfg[F_LINE +: 4]];
      end
      ISRC_CNT: begin
        in_now = ext_now[0];
        in_was = s.ext_prev[0];
      end
      default: begin
        in_now = 1'b0;
        in_was = 1'b0;
      end
    endcase
    out_now = 1'b0;
    out_was = 1'b0;
    unique case (s.out_cfg[F_SRC +: 3])
      OSRC_IO: begin
        out_now = s.io_st[s.out_cfg[F_LINE +: 4]];
        out_was = s.io_prev[s.out_cfg[F_LINE +: 4]];
      end
      OSRC_CNT, OSRC_CHG, OSRC_DI, OSRC_DO: begin
        out_now = ext_now[s.out_cfg[F_SRC +: 2] - 2'h3];
        out_was = s.ext_prev[s.out_cfg[F_SRC +: 2] - 2'h3];
      end
      default: begin
        out_now = 1'b0;
        out_was = 1'b0;
      end
    endcase
  end

  // edge picked from the agreed value on io lines, from the raw input on internal sources, so one pulse per edge
  assign in_trig_ev = (s.in_cfg[F_FALL] ? (in_was & ~in_now) : (in_now & ~in_was)) | cmd[C_IN_SWTRIG];
  assign out_trig_ev = (s.out_cfg[F_FALL] ? (out_was & ~out_now) : (out_now & ~out_was))
    | (s.out_cfg[F_SRC +: 3] == OSRC_SW && cmd[C_OUT_SWTRIG])
    | (s.out_cfg[F_SRC +: 3] == OSRC_IN && s.in_trig);
  assign in_accept = (s.in_st == E_IDLE && cmd[C_IN_START] && !s.in_cfg[F_USE_TRIG])
    || (s.in_st == E_WAIT && in_trig_ev);
  assign out_accept = omode != OM_SW && ((s.out_st == E_IDLE && cmd[C_OUT_START] && !s.out_cfg[F_USE_TRIG])
    || (s.out_st == E_WAIT && out_trig_ev));
  assign in_smp_go = sample_tb_tick && ((s.in_st == E_DELAY && s.in_div <= 8'h01)
    || (s.in_st == E_RUN && s.in_div == 8'h00 && !s.in_last));
  assign out_smp_go = out_tb_tick && ((s.out_st == E_DELAY && s.out_div <= 8'h01)
    || (s.out_st == E_RUN && s.out_div == 8'h00));
  assign out_end = out_smp_go && !s.out_cfg[F_CONT] && (s.out_done + 16'h0001 >= s.out_cnt[15:0]);
  assign conv_tick = s.in_cfg[IC_CONV_TB] ? hf_tb_tick : sample_tb_tick;
  assign o_push = wr_data && (omode == OM_REPEAT_BUFFER
    || (omode == OM_LOCAL_QUEUE_REPLAY && s.out_st == E_IDLE && s.level != QFULL)
    || (omode == OM_NOREGEN && s.level != QFULL));
  assign o_keep = omode == OM_REPEAT_BUFFER && s.level == QFULL;
  assign o_pop = out_smp_go && omode == OM_NOREGEN && s.level != 5'h00;

  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      A_CTRL: rd_val = 32'h0000_0000;
      A_IN_CFG: rd_val = s.in_cfg;
      A_IN_CNT: rd_val = s.in_cnt;
      A_IN_TIM: rd_val = s.in_tim;
      A_OUT_CFG: rd_val = s.out_cfg;
      A_OUT_CNT: rd_val = s.out_cnt;
      A_OUT_TIM: rd_val = s.out_tim;
      A_OUT_DATA: rd_val = {16'h0000, s.dac_data};
      A_ROUTE: rd_val = s.route;
      A_STATUS: begin
        rd_val = 32'h0000_0000;
        rd_val[ST_IN_BUSY] = s.in_st != E_IDLE;
        rd_val[ST_OUT_BUSY] = s.out_st != E_IDLE;
        rd_val[ST_UNDER] = s.underflow;
        rd_val[ST_REFUSED] = s.refused;
        rd_val[ST_LEVEL +: 5] = s.level;
      end
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    n = s;
    n.in_smp = 1'b0;
    n.conv = 1'b0;
    n.in_trig = 1'b0;
    n.out_trig = 1'b0;
    n.out_smp = 1'b0;
    n.dac_upd = 1'b0;
    // three-stage synchroniser, value taken once stages two and three agree
    n.io_q1 = general_io_lines_in;
    n.io_q2 = s.io_q1;
    n.io_q3 = s.io_q2;
    n.io_st = (s.io_q2 & s.io_q3) | (s.io_st & (s.io_q2 | s.io_q3));
    n.io_prev = s.io_st;
    n.ext_prev = ext_now;
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_val;
      n.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_do) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (s.awaddr)
        A_IN_CFG: n.in_cfg = merge(s.in_cfg, s.wdata, s.wstrb);
        A_IN_CNT: n.in_cnt = merge(s.in_cnt, s.wdata, s.wstrb);
        A_IN_TIM: n.in_tim = merge(s.in_tim, s.wdata, s.wstrb);
        A_OUT_CFG: n.out_cfg = merge(s.out_cfg, s.wdata, s.wstrb);
        A_OUT_CNT: n.out_cnt = merge(s.out_cnt, s.wdata, s.wstrb);
        A_OUT_TIM: n.out_tim = merge(s.out_tim, s.wdata, s.wstrb);
        A_ROUTE: n.route = merge(s.route, s.wdata, s.wstrb);
        A_CTRL, A_OUT_DATA, A_STATUS: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // clear first so a same-cycle event still sets the flag
    if (wr_stat && s.wdata[ST_UNDER]) begin
      n.underflow = 1'b0;
    end
    if (wr_stat && s.wdata[ST_REFUSED]) begin
      n.refused = 1'b0;
    end

    // input engine
    if (s.in_st == E_RUN && s.conv_left != 4'h0 && conv_tick) begin
      if (s.conv_div == 8'h00) begin
        n.conv = 1'b1;
        n.conv_left = s.conv_left - 4'h1;
        n.conv_div = (s.in_tim[IT_CDIV +: 8] == 8'h00) ? 8'h00 : s.in_tim[IT_CDIV +: 8] - 8'h01;
      end else begin
        n.conv_div = s.conv_div - 8'h01;
      end
    end
    if (in_accept) begin
      n.in_st = E_DELAY;
      n.in_div = s.in_tim[T_DLY +: 8];
      n.in_done = 16'h0000;
      n.in_last = 1'b0;
      n.in_trig = 1'b1;
    end else if (s.in_st == E_IDLE && cmd[C_IN_START]) begin
      n.in_st = E_WAIT;
    end else if (in_smp_go) begin
      n.in_st = E_RUN;
      n.in_smp = 1'b1;
      n.in_div = in_sdiv_m1;
      n.conv_left = s.in_cfg[IC_NCONV +: 4];
      n.conv_div = 8'h00;
      n.in_done = s.in_done + 16'h0001;
      n.in_last = !s.in_cfg[F_CONT] && (s.in_done + 16'h0001 >= s.in_cnt[15:0]);
    end else if (s.in_st == E_RUN && s.in_last && s.conv_left == 4'h0) begin
      // whole burst done, rearm only when retriggerable
      n.in_st = (s.in_cfg[F_RETRIG] && s.in_cfg[F_USE_TRIG]) ? E_WAIT : E_IDLE;
    end else if (sample_tb_tick && (s.in_st == E_DELAY || s.in_st == E_RUN) && s.in_div != 8'h00) begin
      n.in_div = s.in_div - 8'h01;
    end
    if (cmd[C_IN_STOP]) begin
      n.in_st = E_IDLE;
      n.conv_left = 4'h0;
    end

    // output engine
    if (out_accept) begin
      n.out_st = E_DELAY;
      n.out_div = s.out_tim[T_DLY +: 8];
      n.out_done = 16'h0000;
      n.out_trig = 1'b1;
      if (omode != OM_NOREGEN) begin
        n.rd_ptr = '0;
      end
    end else if (s.out_st == E_IDLE && cmd[C_OUT_START] && omode != OM_SW) begin
      n.out_st = E_WAIT;
    end else if (out_smp_go) begin
      n.out_smp = 1'b1;
      n.out_div = out_sdiv_m1;
      n.out_done = s.out_done + 16'h0001;
      n.out_st = !out_end ? E_RUN : ((s.out_cfg[F_RETRIG] && s.out_cfg[F_USE_TRIG]) ? E_WAIT : E_IDLE);
    end else if (out_tb_tick && (s.out_st == E_DELAY || s.out_st == E_RUN) && s.out_div != 8'h00) begin
      n.out_div = s.out_div - 8'h01;
    end
    if (cmd[C_OUT_STOP]) begin
      n.out_st = E_IDLE;
    end

    // sample data path
    if (out_smp_go && s.level != 5'h00) begin
      n.dac_upd = 1'b1;
      n.dac_data = s.mem[s.rd_ptr];
      if (omode == OM_NOREGEN || {1'b0, s.rd_ptr} + 5'h01 != s.level) begin
        n.rd_ptr = s.rd_ptr + 4'h1;
      end else begin
        n.rd_ptr = '0;
      end
    end
    if (out_smp_go && omode == OM_NOREGEN && s.level == 5'h00) begin
      n.underflow = 1'b1;
    end
    if (wr_data && omode == OM_SW) begin
      n.dac_upd = 1'b1;
      n.dac_data = s.wdata[SW-1:0];
    end
    if (o_push) begin
      n.mem[s.wr_ptr] = s.wdata[SW-1:0];
      n.wr_ptr = s.wr_ptr + 4'h1;
    end
    if (wr_data && !o_push && omode != OM_SW) begin
      n.refused = 1'b1;
    end
    n.level = s.level + {4'h0, o_push && !o_keep} - {4'h0, o_pop};
    if (cmd[C_FLUSH]) begin
      n.wr_ptr = '0;
      n.rd_ptr = '0;
      n.level = 5'h00;
    end

    // terminal routing; the conversion timebase has no route at all
    for (int i = 0; i < 16; i++) begin
      n.io_oe[i] = (n.route[RT_HOLD_EN] && n.route[RT_HOLD_LINE +: 4] == i[3:0])
        || (n.route[RT_IN_EN] && n.route[RT_IN_LINE +: 4] == i[3:0])
        || (n.route[RT_OUT_EN] && n.route[RT_OUT_LINE +: 4] == i[3:0]);
      n.io_out[i] = ((n.route[RT_HOLD_EN] && n.route[RT_HOLD_LINE +: 4] == i[3:0])
          && (n.conv ^ n.route[RT_HOLD_POL]))
        || ((n.route[RT_IN_EN] && n.route[RT_IN_LINE +: 4] == i[3:0]) && n.in_trig)
        || ((n.route[RT_OUT_EN] && n.route[RT_OUT_LINE +: 4] == i[3:0]) && n.out_trig);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= rst_val;
    end else if (ce) begin
      s <= n;
    end
  end

  assign general_io_lines_out = s.io_out;
  assign general_io_lines_oe = s.io_oe;
  assign in_sample_clk = s.in_smp;
  assign conv_clk = s.conv;
  assign hold_done_pulse = s.conv;
  assign input_start_trigger = s.in_trig;
  assign output_start_trigger = s.out_trig;
  assign out_sample_clk = s.out_smp;
  assign dac_update = s.dac_upd;
  assign dac_data = s.dac_data;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_in_armed;
    ce && s.in_st == E_WAIT && !cmd[C_IN_STOP];
  endsequence
  sequence s_in_fired;
    input_start_trigger && s.in_st == E_DELAY;
  endsequence

  a_in_trig_start: assert property (s_in_armed ##0 in_trig_ev |=> s_in_fired)
    else $error("armed input trigger not accepted");
  a_in_burst_ignore: assert property (ce && s.in_st == E_RUN && in_trig_ev |=> !input_start_trigger)
    else $error("input trigger accepted during burst");
  a_in_first_smp: assert property (ce && s.in_st == E_DELAY && sample_tb_tick && s.in_div <= 8'h01
    && !cmd[C_IN_STOP] |=> in_sample_clk && s.in_st == E_RUN)
    else $error("first input sample not after delay");
  a_in_finite_end: assert property (ce && s.in_st == E_RUN && s.in_last && s.conv_left == 4'h0
    && !(s.in_cfg[F_RETRIG] && s.in_cfg[F_USE_TRIG]) |=> s.in_st == E_IDLE)
    else $error("finite acquisition did not stop");
  a_hold_route_level: assert property (hold_done_pulse && s.route[RT_HOLD_EN]
    |-> general_io_lines_out[s.route[RT_HOLD_LINE +: 4]] == !s.route[RT_HOLD_POL]
    && general_io_lines_oe[s.route[RT_HOLD_LINE +: 4]])
    else $error("hold pulse not on routed line");
  a_sw_update_once: assert property (ce && wr_data && omode == OM_SW
    |=> dac_update && dac_data == $past(s.wdata[SW-1:0]))
    else $error("software update missing");
  a_underflow_set: assert property (ce && out_smp_go && omode == OM_NOREGEN && s.level == 5'h00 |=> s.underflow)
    else $error("underflow not flagged");
  a_local_refuse: assert property (ce && wr_data && omode == OM_LOCAL_QUEUE_REPLAY && s.out_st != E_IDLE
    |=> s.refused && s.level == $past(s.level))
    else $error("write during local replay not refused");
  a_out_burst_ignore: assert property (ce && s.out_st == E_RUN && out_trig_ev |=> !output_start_trigger)
    else $error("output trigger accepted during burst");
endmodule
`default_nettype wire

// ---- sim/atg_top_tb.sv ----
// self-checking bench for the trigger and timing block
`timescale 1ns/1ps
`default_nettype none
module atg_top_tb import atg_pkg::*;;
  logic aclk = 0, aresetn = 0, tk = 0, fire = 0, ce = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rv;
  logic [1:0] tc = 0, rr, bresp, rresp;
  logic [3:0] fl = 0;
  logic awready, wready, bvalid, arready, rvalid, isc, cc, hd, ist, ost, osc, du;
  logic [31:0] rdata;
  logic [15:0] io_out, io_oe, src_io, io_in, dd;
  int failures = 0, checks = 0, cyc = 0, ns = 0, nc = 0, nt = 0, nd = 0, no = 0;
  always #20 aclk = ~aclk;
  // released lines follow the source, routed lines loop back
  assign io_in = (io_oe & io_out) | (~io_oe & src_io);
  atg_trig_src u_atg_trig_src (.aclk(aclk), .fire(fire), .line(fl), .pins(src_io));
  atg_top u_atg_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .general_io_lines_in(io_in), .general_io_lines_out(io_out),
    .general_io_lines_oe(io_oe), .counter_out(1'b0), .change_detect(1'b0),
    .digital_in_start_trigger(1'b0), .digital_out_start_trigger(1'b0), .sample_tb_tick(tk),
    .hf_tb_tick(tk), .out_tb_tick(tk), .in_sample_clk(isc), .conv_clk(cc), .hold_done_pulse(hd),
    .input_start_trigger(ist), .output_start_trigger(ost), .out_sample_clk(osc),
    .dac_update(du), .dac_data(dd));
  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    checks++;
    if (a !== e) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // tick every fourth cycle; pulses counted, routed copies compared
  always @(posedge aclk) begin
    tc <= tc + 2'h1;
    tk <= (tc == 2'h3);
    if (isc === 1'b1) ns <= ns + 1;
    if (cc === 1'b1) nc <= nc + 1;
    if (du === 1'b1) nd <= nd + 1;
    if (osc === 1'b1) no <= no + 1;
    if (ist === 1'b1) nt <= nt + 1;
    if (ist === 1'b1) chk(32'h1, {31'h0, io_out[9]});
    if (hd === 1'b1) chk(32'h0, {31'h0, io_out[3]});
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      wrap_up;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic da, dw, ta, tw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = awready && !da;
      tw = wready && !dw;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        da = 1'b1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        dw = 1'b1;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic idle(input int b);
    for (int i = 0; i < 100; i++) begin
      rd(A_STATUS, rv, rr);
      if (rv[b] === 1'b0) break;
    end
  endtask
  task automatic upto(ref int c, input int e);
    for (int i = 0; i < 400 && c < e; i++) @(posedge aclk);
  endtask
  task automatic pulse(input logic [3:0] l);
    @(posedge aclk);
    fl <= l;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_IN_TIM, rv, rr);
    chk(32'h4, {24'h0, rv[7:0]});
    rd(A_OUT_TIM, rv, rr);
    chk(32'h2, {24'h0, rv[7:0]});
    rd(8'h28, rv, rr);
    chk({30'h0, RESP_SLVERR}, {30'h0, rr});
    // frozen block must refuse the read address handshake
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'h0, {31'h0, arready});
    ce <= 1'b1;
    // hold on line 3 active low, input trigger on line 9
    wr(A_ROUTE, 32'h0009_1131);
    repeat (2) @(posedge aclk);
    chk(32'h0208, {16'h0, io_oe});
    chk(32'h1, {31'h0, io_out[3]});
    // three ticks per sample, so both conversions land on ticks before the next sample
    wr(A_IN_TIM, 32'h0001_0304);
    wr(A_IN_CNT, 32'h2);
    wr(A_IN_CFG, 32'h0002_1000);
    wr(A_CTRL, 32'h1);
    idle(ST_IN_BUSY);
    chk(32'h2, ns);
    chk(32'h4, nc);
    chk(32'h1, nt);
    wr(A_IN_CFG, 32'h0001_0503);
    wr(A_CTRL, 32'h1);
    pulse(4'h5);
    upto(nt, 2);
    // line low long enough to pass the filter, so a real second edge lands in the burst
    repeat (4) @(posedge aclk);
    pulse(4'h5);
    upto(ns, 4);
    repeat (60) @(posedge aclk);
    chk(32'h2, nt);
    chk(32'h4, ns);
    pulse(4'h5);
    upto(ns, 6);
    chk(32'h3, nt);
    chk(32'h6, ns);
    wr(A_CTRL, 32'h2);
    // armed with software-only source, fired by the trigger command
    wr(A_IN_CFG, 32'h0001_0021);
    wr(A_CTRL, 32'h1);
    wr(A_CTRL, 32'h4);
    idle(ST_IN_BUSY);
    chk(32'h4, nt);
    chk(32'h8, ns);
    wr(A_OUT_DATA, 32'h1234);
    wr(A_OUT_DATA, 32'hbeef);
    repeat (2) @(posedge aclk);
    chk(32'h2, nd);
    chk(32'hbeef, {16'h0, dd});
    wr(A_OUT_CFG, 32'h0000_3001);
    wr(A_CTRL, 32'h40);
    wr(A_OUT_CNT, 32'h2);
    wr(A_OUT_DATA, 32'h5a3c);
    wr(A_CTRL, 32'h08);
    wr(A_CTRL, 32'h20);
    idle(ST_OUT_BUSY);
    chk(32'h2, no);
    chk(32'h3, nd);
    chk(32'h5a3c, {16'h0, dd});
    chk(32'h1, {31'h0, rv[ST_UNDER]});
    // local replay, untriggered: one word replayed, write while running refused
    wr(A_OUT_CFG, 32'h0000_2000);
    wr(A_OUT_CNT, 32'h3);
    wr(A_CTRL, 32'h40);
    wr(A_OUT_DATA, 32'h0077);
    wr(A_CTRL, 32'h08);
    wr(A_OUT_DATA, 32'h0099);
    idle(ST_OUT_BUSY);
    chk(32'h1, {31'h0, rv[ST_REFUSED]});
    chk(32'h1, {27'h0, rv[ST_LEVEL +: 5]});
    chk(32'h5, no);
    chk(32'h6, nd);
    chk(32'h77, {16'h0, dd});
    wrap_up;
  end
endmodule
`default_nettype wire

// ---- sim/atg_trig_src.sv ----
// external trigger source driving the general io lines
`timescale 1ns/1ps
`default_nettype none
module atg_trig_src (
  // clock
  input wire logic aclk,
  // pulse request
  input wire logic fire,
  input wire logic [3:0] line,
  // pins
  output logic [15:0] pins
);
  logic [3:0] left_ff = 4'h0;
  logic [3:0] line_ff = 4'h0;
  // held 8 cycles so the three-flop synchroniser cannot miss it
  always @(posedge aclk) begin
    if (fire) begin
      left_ff <= 4'h8;
      line_ff <= line;
    end else if (left_ff != 4'h0) begin
      left_ff <= left_ff - 4'h1;
    end
  end
  assign pins = (left_ff != 4'h0) ? (16'h0001 << line_ff) : 16'h0000;
endmodule
`default_nettype wire
